/* rtl/flash_ctl_defs.svh */
// register offsets, field positions, reset values and timing of the flash controller
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH
`define OFF_CONTROL 8'h00
`define OFF_UNLOCK_KEY 8'h04
`define OFF_ADDR_LOW 8'h08
`define OFF_ADDR_HIGH 8'h0c
`define OFF_DATA_LOW 8'h10
`define OFF_DATA_HIGH 8'h14
`define BIT_READ_START 0
`define BIT_WRITE_START 1
`define BIT_WRITE_ALLOW 2
`define BIT_WRITE_ABORT 3
`define BIT_ROW_ERASE 4
`define BIT_LATCH_ONLY 5
`define BIT_CONFIG_SPACE 6
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define WORD_BLANK 14'h3fff
`define ROW_WORDS_DEFAULT 16
`define MEM_WORDS_DEFAULT 512
`define UID_WORDS 4
`define CFG_ADDR_DEV_ID 9'h006
`define CFG_ADDR_CONFIG 9'h007
`define REF_CLK_MHZ 25
`define WRITE_TIME_US 2000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* rtl/flash_ctl_pkg.sv */
// types shared by the self-write flash controller
`default_nettype none
package flash_ctl_pkg;
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_RD_WAIT,
		SEQ_RD_ACCESS,
		SEQ_NOP_FIRST,
		SEQ_NOP_SECOND,
		SEQ_BUSY
	} seq_state_t;
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
	typedef enum logic [1:0] {OP_ERASE, OP_LATCH, OP_PROGRAM} op_kind_t;
	typedef struct packed {
		logic config_space_select;
		logic latch_only_load;
		logic row_erase_select;
		logic write_allow;
		logic write_start;
		logic read_start;
	} ctrl_t;
	typedef struct packed {
		logic force_nop;
		logic stall;
	} core_ctl_t;
endpackage : flash_ctl_pkg
`default_nettype wire

/* rtl/self_write_flash_controller.sv */
// self-write flash controller: register slave, unlock, sequencer and array
// Behaviour
// - read/write start bits are set-only; hardware clears them when done
// - erase/write only with write_allow set; it powers up cleared
// - a reset during a running write sets write_abort_flag
// - unlock key register is write-only and reads as zero
// - memory is organised in rows of 14-bit words; row is erase unit
// - 14-bit write latches load only through the data register pair
// - row size and latch count are one parameter, 16 or 10
// - read uses the second cycle; data pair holds result right after
// - data pair keeps read value until next read or software write
// - erase, latch load and programming need an unbroken unlock
// - setting write start forces two no_operation cycles
// - row erase or program stalls the core for the write time
// - latch-only load forces two no_operation cycles without stall
// - the stall keeps clocks and peripherals running; it is no sleep
// - after erase execution resumes at third slot after write start
// - programming ANDs into words; other words of the row stay
// - address pair gives a 9-bit word address; data pair 14 bits
// - latch_only_load one loads a latch; zero programs the row
// - all latches return to 3FFFh after each write or erase
// - config select targets user id, device id and config words
`include "flash_ctl_defs.svh"
`default_nettype none
module self_write_flash_controller #(
	parameter int unsigned ROW_WORDS = `ROW_WORDS_DEFAULT,
	parameter int unsigned MEM_WORDS = `MEM_WORDS_DEFAULT,
	parameter int unsigned WRITE_CYCLES = `WRITE_TIME_US * `REF_CLK_MHZ,
	// arbitrary identification value
	parameter logic [13:0] DEV_ID_WORD = 14'h0123,
	parameter logic [13:0] CONFIG_WORD = 14'h0000
) (
	// clock and resets
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic por_n,
	// axi4-lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// axi4-lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// core execution control
	output flash_ctl_pkg::core_ctl_t core_ctl
);
	import flash_ctl_pkg::*;

	localparam int LW = (ROW_WORDS > 1) ? $clog2(ROW_WORDS) : 1;

	logic [13:0] mem_q [MEM_WORDS];
	logic [13:0] latch_q [ROW_WORDS];
	logic [13:0] uid_q [`UID_WORDS];
	seq_state_t state_reg;
	key_state_t key_reg;
	op_kind_t kind_reg;
	logic go_reg;
	ctrl_t ctl_reg;
	logic abort_reg;
	logic op_active_reg;
	logic [8:0] addr_reg;
	logic [13:0] data_reg;
	logic [31:0] cnt_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic w_lane_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rd_value;
	logic [13:0] rd_word;
	logic seq_idle;
	logic wr_fire;
	logic wr_en;
	logic wr_map;
	logic rd_fire;
	logic wr_ctl;
	logic start_wr;
	logic start_rd;
	logic latch_write;
	logic commit;
	logic done_wr;
	logic [LW-1:0] lidx;
	logic [31:0] stall_len;

	assign seq_idle = (state_reg == SEQ_IDLE);
	// bus waits while the core is stalled or forced
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg && seq_idle;
	assign wr_en = wr_fire && w_lane_reg;
	assign wr_map = aw_addr_reg inside {`OFF_CONTROL, `OFF_UNLOCK_KEY,
		`OFF_ADDR_LOW, `OFF_ADDR_HIGH, `OFF_DATA_LOW, `OFF_DATA_HIGH};
	assign s_axi_arready = !rvalid_reg && seq_idle;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign wr_ctl = wr_en && (aw_addr_reg == `OFF_CONTROL);
	assign start_wr = wr_ctl && w_data_reg[`BIT_WRITE_START];
	assign start_rd = wr_ctl && w_data_reg[`BIT_READ_START]
		&& !w_data_reg[`BIT_WRITE_START];
	assign latch_write = (state_reg == SEQ_NOP_SECOND) && go_reg
		&& (kind_reg != OP_ERASE);
	assign commit = (state_reg == SEQ_BUSY) && (cnt_reg == 32'h0);
	assign done_wr = commit || ((state_reg == SEQ_NOP_SECOND)
		&& !(go_reg && kind_reg != OP_LATCH));
	assign lidx = LW'(32'(addr_reg) % ROW_WORDS);
	// clocks keep running during the stall; only execution is held
	assign core_ctl.stall = (state_reg == SEQ_BUSY);
	assign core_ctl.force_nop = (state_reg == SEQ_RD_WAIT)
		|| (state_reg == SEQ_RD_ACCESS) || (state_reg == SEQ_NOP_FIRST)
		|| (state_reg == SEQ_NOP_SECOND);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_hold_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			w_hold_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_lane_reg <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_lane_reg <= s_axi_wstrb[0];
		end
		else if (wr_fire)
			w_hold_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	always_comb
	begin
		rd_value = 32'h0;
		unique case (s_axi_araddr)
			`OFF_CONTROL: rd_value = {25'h0, ctl_reg.config_space_select,
				ctl_reg.latch_only_load, ctl_reg.row_erase_select, abort_reg,
				ctl_reg.write_allow, ctl_reg.write_start, ctl_reg.read_start};
			`OFF_UNLOCK_KEY: rd_value = 32'h0;
			`OFF_ADDR_LOW: rd_value = {24'h0, addr_reg[7:0]};
			`OFF_ADDR_HIGH: rd_value = {31'h0, addr_reg[8]};
			`OFF_DATA_LOW: rd_value = {24'h0, data_reg[7:0]};
			`OFF_DATA_HIGH: rd_value = {26'h0, data_reg[13:8]};
			default: rd_value = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_value;
			rresp_reg <= (s_axi_araddr inside {`OFF_CONTROL, `OFF_UNLOCK_KEY,
				`OFF_ADDR_LOW, `OFF_ADDR_HIGH, `OFF_DATA_LOW, `OFF_DATA_HIGH})
				? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			ctl_reg <= '0;
		else
		begin
			if (wr_ctl)
			begin
				ctl_reg.write_allow <= w_data_reg[`BIT_WRITE_ALLOW];
				ctl_reg.row_erase_select <= w_data_reg[`BIT_ROW_ERASE];
				ctl_reg.latch_only_load <= w_data_reg[`BIT_LATCH_ONLY];
				ctl_reg.config_space_select <= w_data_reg[`BIT_CONFIG_SPACE];
			end
			// a written zero never clears a start bit
			if (start_rd)
				ctl_reg.read_start <= 1'b1;
			else if (state_reg == SEQ_RD_ACCESS)
				ctl_reg.read_start <= 1'b0;
			if (start_wr)
				ctl_reg.write_start <= 1'b1;
			else if (done_wr)
				ctl_reg.write_start <= 1'b0;
		end
	end

	// any other register write between the keys breaks the sequence
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			key_reg <= KEY_IDLE;
		else if (wr_en)
		begin
			if (aw_addr_reg != `OFF_UNLOCK_KEY)
				key_reg <= KEY_IDLE;
			else if (w_data_reg == `KEY_FIRST)
				key_reg <= KEY_GOT_FIRST;
			else if (w_data_reg == `KEY_SECOND && key_reg == KEY_GOT_FIRST)
				key_reg <= KEY_ARMED;
			else
				key_reg <= KEY_IDLE;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= SEQ_IDLE;
			go_reg <= 1'b0;
			kind_reg <= OP_ERASE;
			cnt_reg <= 32'h0;
		end
		else
		begin
			unique case (state_reg)
				SEQ_IDLE:
					if (start_wr)
					begin
						state_reg <= SEQ_NOP_FIRST;
						go_reg <= (key_reg == KEY_ARMED)
							&& w_data_reg[`BIT_WRITE_ALLOW];
						kind_reg <= w_data_reg[`BIT_ROW_ERASE] ? OP_ERASE
							: (w_data_reg[`BIT_LATCH_ONLY] ? OP_LATCH
							: OP_PROGRAM);
					end
					else if (start_rd)
						state_reg <= SEQ_RD_WAIT;
				SEQ_RD_WAIT: state_reg <= SEQ_RD_ACCESS;
				SEQ_RD_ACCESS: state_reg <= SEQ_IDLE;
				SEQ_NOP_FIRST: state_reg <= SEQ_NOP_SECOND;
				SEQ_NOP_SECOND:
					if (go_reg && kind_reg != OP_LATCH)
					begin
						state_reg <= SEQ_BUSY;
						cnt_reg <= WRITE_CYCLES - 32'd1;
					end
					else
						state_reg <= SEQ_IDLE;
				SEQ_BUSY:
					if (cnt_reg == 32'h0)
						state_reg <= SEQ_IDLE;
					else
						cnt_reg <= cnt_reg - 32'd1;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			addr_reg <= 9'h000;
		else if (wr_en && aw_addr_reg == `OFF_ADDR_LOW)
			addr_reg[7:0] <= w_data_reg;
		else if (wr_en && aw_addr_reg == `OFF_ADDR_HIGH)
			addr_reg[8] <= w_data_reg[0];
	end

	always_comb
	begin
		rd_word = 14'h0;
		if (ctl_reg.config_space_select)
		begin
			if (addr_reg < 9'(`UID_WORDS))
				rd_word = uid_q[addr_reg[1:0]];
			else if (addr_reg == `CFG_ADDR_DEV_ID)
				rd_word = DEV_ID_WORD;
			else if (addr_reg == `CFG_ADDR_CONFIG)
				rd_word = CONFIG_WORD;
		end
		else if (32'(addr_reg) < MEM_WORDS)
			rd_word = mem_q[addr_reg];
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			data_reg <= 14'h0;
		else if (state_reg == SEQ_RD_ACCESS)
			data_reg <= rd_word;
		else if (wr_en && aw_addr_reg == `OFF_DATA_LOW)
			data_reg[7:0] <= w_data_reg;
		else if (wr_en && aw_addr_reg == `OFF_DATA_HIGH)
			data_reg[13:8] <= w_data_reg[5:0];
	end

	// survives nrst so the interrupted write is still visible afterwards
	always_ff @(posedge ref_clk or negedge por_n)
	begin
		if (!por_n)
		begin
			op_active_reg <= 1'b0;
			abort_reg <= 1'b0;
		end
		else if (!nrst)
		begin
			if (op_active_reg)
			begin
				abort_reg <= 1'b1;
				op_active_reg <= 1'b0;
			end
		end
		else
		begin
			if (latch_write && kind_reg == OP_PROGRAM)
				op_active_reg <= 1'b1;
			else if (state_reg == SEQ_NOP_SECOND && go_reg
				&& kind_reg == OP_ERASE)
				op_active_reg <= 1'b1;
			else if (commit)
				op_active_reg <= 1'b0;
			if (wr_ctl && !w_data_reg[`BIT_WRITE_ABORT])
				abort_reg <= 1'b0;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < ROW_WORDS; gi++)
		begin : g_latch
			always_ff @(posedge ref_clk or negedge nrst)
			begin
				if (!nrst)
					latch_q[gi] <= `WORD_BLANK;
				else if (commit)
					latch_q[gi] <= `WORD_BLANK;
				else if (latch_write && lidx == LW'(gi))
					latch_q[gi] <= data_reg;
			end
		end
		for (gi = 0; gi < MEM_WORDS; gi++)
		begin : g_mem
			// row membership is fixed per word; only the address is divided per cycle
			always_ff @(posedge ref_clk or negedge por_n)
			begin
				if (!por_n)
					mem_q[gi] <= `WORD_BLANK;
				else if (commit && !ctl_reg.config_space_select
					&& (32'(addr_reg) / ROW_WORDS) == (gi / ROW_WORDS))
					mem_q[gi] <= (kind_reg == OP_ERASE) ? `WORD_BLANK
						: (mem_q[gi] & latch_q[gi % ROW_WORDS]);
			end
		end
		for (gi = 0; gi < `UID_WORDS; gi++)
		begin : g_uid
			always_ff @(posedge ref_clk or negedge por_n)
			begin
				if (!por_n)
					uid_q[gi] <= `WORD_BLANK;
				else if (commit && ctl_reg.config_space_select
					&& addr_reg < 9'(`UID_WORDS))
					uid_q[gi] <= (kind_reg == OP_ERASE) ? `WORD_BLANK
						: (uid_q[gi] & latch_q[gi % ROW_WORDS]);
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			stall_len <= 32'h0;
		else if (core_ctl.stall)
			stall_len <= stall_len + 32'd1;
		else
			stall_len <= 32'h0;
	end

	a_key_reads_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rd_fire && s_axi_araddr == `OFF_UNLOCK_KEY)
		|=> (s_axi_rvalid && s_axi_rdata == 32'h0))
		else $error("unlock key read not zero");
	a_read_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(ctl_reg.read_start)
		|-> core_ctl.force_nop [*2] ##1 !ctl_reg.read_start)
		else $error("read start not cleared after two cycles");
	a_read_data: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == SEQ_RD_ACCESS) |=> (data_reg == $past(rd_word)))
		else $error("read data not loaded");
	a_write_nops: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(ctl_reg.write_start) |-> core_ctl.force_nop [*2])
		else $error("two forced cycles missing");
	a_no_unlock: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == SEQ_NOP_SECOND && !go_reg)
		|=> (seq_idle && !core_ctl.stall && !ctl_reg.write_start))
		else $error("operation ran without unlock");
	a_latch_nostall: assert property (@(posedge ref_clk) disable iff (!nrst)
		(state_reg == SEQ_NOP_SECOND && go_reg && kind_reg == OP_LATCH)
		|=> (seq_idle && !core_ctl.stall))
		else $error("latch load stalled");
	a_stall_length: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(core_ctl.stall) |-> (stall_len == WRITE_CYCLES))
		else $error("stall length wrong");
	a_allow_busy: assert property (@(posedge ref_clk) disable iff (!nrst)
		core_ctl.stall |-> ctl_reg.write_allow)
		else $error("stall without write allow");
	a_latch_blank: assert property (@(posedge ref_clk) disable iff (!nrst)
		commit |=> (latch_q[0] == `WORD_BLANK && seq_idle))
		else $error("latches not blank after write");
	a_abort_set: assert property (@(posedge ref_clk) disable iff (!por_n)
		(!nrst && op_active_reg) |=> abort_reg)
		else $error("abort flag not set");
endmodule : self_write_flash_controller
`default_nettype wire

/* verification/core_model.sv */
// processor core model: counts forced, stalled and issued cycles
`default_nettype none
module core_model
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// execution control from the controller
	input wire flash_ctl_pkg::core_ctl_t core_ctl,
	// activity counts
	output int nops,
	output int stalls,
	output int insns
);
	timeunit 1ns;
	timeprecision 1ps;
	import flash_ctl_pkg::*;
	// a forced slot replaces the fetched instruction, so it wins over stall
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			nops <= 0;
			stalls <= 0;
			insns <= 0;
		end
		else if (core_ctl.force_nop)
			nops <= nops + 1;
		else if (core_ctl.stall)
			stalls <= stalls + 1;
		else
			insns <= insns + 1;
	end
endmodule : core_model
`default_nettype wire

/* verification/test_self_write_flash_controller.sv */
// testbench of the self-write flash controller
`include "flash_ctl_defs.svh"
`default_nettype none
module test_self_write_flash_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_ctl_pkg::*;
	localparam int WCYC = 20;
	// arbitrary identification value
	localparam logic [13:0] DEV_ID = 14'h0123;
	logic ref_clk, nrst, por_n;
	logic awvalid, awready, wvalid, wready, bvalid;
	logic arvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, resp;
	logic [13:0] w;
	core_ctl_t core_ctl;
	int nops, stalls, insns, cyc, n_mismatch, num_checks, n0, s0;

	self_write_flash_controller #(.WRITE_CYCLES(WCYC),
		.DEV_ID_WORD(DEV_ID)) DUT (.ref_clk(ref_clk), .nrst(nrst),
		.por_n(por_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.core_ctl(core_ctl));
	core_model partner (.ref_clk(ref_clk), .nrst(nrst),
		.core_ctl(core_ctl), .nops(nops), .stalls(stalls), .insns(insns));

	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// the stall of an aborted erase plus the power-on wait fit well inside
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (awready === 1'b1 && !ad)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !dd)
			begin
				dd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!(ad && dd));
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		resp = bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
	endtask : rd

	// address first, then config select from c and read start in one control write
	task automatic rdw(input logic [8:0] a, input logic [7:0] c,
		output logic [13:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		wr(8'h08, a[7:0]);
		wr(8'h0c, {7'h0, a[8]});
		wr(8'h00, c | 8'h01);
		rd(8'h10, lo);
		rd(8'h14, hi);
		v = {hi[5:0], lo[7:0]};
	endtask : rdw

	task automatic unlock(input logic [7:0] c);
		// nothing else reaches the bus in between, as with interrupts off
		wr(8'h04, `KEY_FIRST);
		wr(8'h04, `KEY_SECOND);
		wr(8'h00, c | 8'h06);
	endtask : unlock

	task automatic t_reset;
		rd(8'h00, d);
		chk("control", 32'h0, d);
		wr(8'h04, `KEY_FIRST);
		rd(8'h04, d);
		chk("key read", 32'h0, d);
		rd(8'h18, d);
		chk("rresp", `RESP_SLVERR, resp);
		wr(8'h18, 8'h5a);
		chk("bresp", `RESP_SLVERR, resp);
	endtask : t_reset

	task automatic t_read_blank;
		n0 = nops;
		rdw(9'h1f3, 8'h00, w);
		chk("blank word", 14'h3fff, w);
		chk("read nops", n0 + 2, nops);
		rd(8'h00, d);
		chk("read start", 32'h0, d);
	endtask : t_read_blank

	task automatic t_program;
		wr(8'h08, 8'h23);
		wr(8'h0c, 8'h00);
		wr(8'h10, 8'h34);
		wr(8'h14, 8'h12);
		n0 = nops;
		s0 = stalls;
		unlock(8'h20);
		rd(8'h00, d);
		chk("latch ctrl", 32'h24, d);
		chk("latch stall", s0, stalls);
		chk("latch nops", n0 + 2, nops);
		wr(8'h08, 8'h24);
		wr(8'h10, 8'hbc);
		wr(8'h14, 8'h0a);
		unlock(8'h00);
		rd(8'h00, d);
		chk("prog ctrl", 32'h04, d);
		chk("prog stall", s0 + WCYC, stalls);
		rdw(9'h023, 8'h00, w);
		chk("word 23", 14'h1234, w);
		rdw(9'h024, 8'h00, w);
		chk("word 24", 14'h0abc, w);
		rdw(9'h025, 8'h00, w);
		chk("word 25", 14'h3fff, w);
		wr(8'h08, 8'h26);
		wr(8'h10, 8'h55);
		wr(8'h14, 8'h01);
		unlock(8'h00);
		rdw(9'h026, 8'h00, w);
		chk("word 26", 14'h0155, w);
		rdw(9'h023, 8'h00, w);
		chk("word 23 kept", 14'h1234, w);
	endtask : t_program

	task automatic t_refuse;
		s0 = stalls;
		wr(8'h08, 8'h25);
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h00, 8'h06);
		rd(8'h00, d);
		chk("nokey ctrl", 32'h04, d);
		wr(8'h04, `KEY_FIRST);
		wr(8'h04, `KEY_SECOND);
		wr(8'h00, 8'h02);
		rdw(9'h025, 8'h00, w);
		chk("refused word", 14'h3fff, w);
		chk("refused stall", s0, stalls);
	endtask : t_refuse

	task automatic t_erase;
		s0 = stalls;
		wr(8'h08, 8'h2b);
		wr(8'h0c, 8'h00);
		unlock(8'h10);
		rd(8'h00, d);
		chk("erase ctrl", 32'h14, d);
		chk("erase stall", s0 + WCYC, stalls);
		rdw(9'h023, 8'h00, w);
		chk("erased 23", 14'h3fff, w);
		rdw(9'h026, 8'h00, w);
		chk("erased 26", 14'h3fff, w);
	endtask : t_erase

	task automatic t_config;
		rdw(9'h006, 8'h40, w);
		chk("device id", DEV_ID, w);
		rdw(9'h005, 8'h40, w);
		chk("config hole", 14'h0, w);
	endtask : t_config

	task automatic t_abort;
		wr(8'h08, 8'h40);
		unlock(8'h10);
		do @(posedge ref_clk); while (core_ctl.stall !== 1'b1);
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(8'h00, d);
		chk("abort flag", 32'h08, d);
		wr(8'h00, 8'h00);
		rd(8'h00, d);
		chk("abort clear", 32'h0, d);
	endtask : t_abort

	initial
	begin
		{nrst, por_n, awvalid, wvalid, arvalid} = '0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		por_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_read_blank();
		// power-on settling before any unlock
		repeat (2500) @(posedge ref_clk);
		t_program();
		t_refuse();
		t_erase();
		t_config();
		t_abort();
		conclude();
	end
endmodule : test_self_write_flash_controller
`default_nettype wire
